// *** hdl/fbimg_device.sv ***
// device end: builds the cyclic input image and answers dictionary access
`timescale 1ns/1ps
// Behaviour
// - refresh on own timers, never bus-synchronised
// - electrical value refreshed every 0.52 ms
// - six inter-device bus values every 1 ms
// - six calculation results every 1 ms
// - four limit values only on events
// - first external value every 1 ms
// - analog output at 0.52 or 1 ms
// - control word echoed every 1 ms
// - active parameter set number on change only
// - read reply: index, subindex, error, value
// - floats returned as raw bit patterns
// - write reply: index, subindex, error byte
// - 32-bit full field, 8-bit in low byte
// - 16-bit objects in bits 15..0
// - act only on changed request, skip index zero
module fbimg_device
    import fbimg_pkg::*;
#(
    parameter int FAST_CYC = FAST_CYC_DEF,
    parameter int SLOW_CYC = SLOW_CYC_DEF
) (
    input  wire logic                     SYS_CLK,
    input  wire logic                     RST_N,
    input  wire logic [31:0]              ELEC_IN,
    input  wire logic [N_BUS-1:0][31:0]   BUS_IN,
    input  wire logic [N_CALC-1:0][31:0]  CALC_IN,
    input  wire logic [N_LIMIT-1:0][31:0] LIMIT_IN,
    input  wire logic [N_LIMIT-1:0]       LIMIT_EVT,
    input  wire logic [31:0]              EXT_IN,
    input  wire logic [31:0]              AOUT_IN,
    input  wire logic                     AOUT_FAST,
    input  wire logic [15:0]              PSET_IN,
    output logic      [31:0]              CTRL_WORD_OUT,
    fbimg_if.dev                          LINK
);
    logic [TW-1:0]              fcnt_r, scnt_r;
    logic                       ftick_r, stick_r, rd_go, wr_go;
    logic [31:0]                elec_r, ext_r, aout_r, ctrl_rx_r, echo_r;
    logic [31:0]                obj_u32_r, rd_last_r, rd_val_r, prd_val_r;
    logic [31:0]                rd_cur, rd_val_nxt;
    logic [63:0]                wr_last_r, wr_cur;
    logic [N_BUS-1:0][31:0]     bus_r;
    logic [N_CALC-1:0][31:0]    calc_r;
    logic [N_LIMIT-1:0][31:0]   limit_r;
    logic [15:0]                pset_r, obj_u16_r;
    logic [15:0]                rd_idx_r, wr_idx_r, prd_idx_r, pwr_idx_r;
    logic [7:0]                 obj_u8_r, rd_sub_r, rd_err_r, wr_sub_r;
    logic [7:0]                 wr_err_r, prd_sub_r, prd_err_r, pwr_sub_r;
    logic [7:0]                 pwr_err_r, rd_err_nxt, wr_err_nxt;

    // free-running refresh timers, independent of any bus timing
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            fcnt_r  <= '0;
            ftick_r <= 1'b0;
        end else if (fcnt_r == TW'(FAST_CYC - 1)) begin
            fcnt_r  <= '0;
            ftick_r <= 1'b1;
        end else begin
            fcnt_r  <= fcnt_r + 1'b1;
            ftick_r <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            scnt_r  <= '0;
            stick_r <= 1'b0;
        end else if (scnt_r == TW'(SLOW_CYC - 1)) begin
            scnt_r  <= '0;
            stick_r <= 1'b1;
        end else begin
            scnt_r  <= scnt_r + 1'b1;
            stick_r <= 1'b0;
        end
    end

    // periodic image values
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            elec_r <= '0;
            bus_r  <= '0;
            calc_r <= '0;
            ext_r  <= '0;
            aout_r <= '0;
        end else begin
            if (ftick_r) begin
                elec_r <= ELEC_IN;
            end
            if (stick_r) begin
                bus_r  <= BUS_IN;
                calc_r <= CALC_IN;
                ext_r  <= EXT_IN;
            end
            if (AOUT_FAST ? ftick_r : stick_r) begin
                aout_r <= AOUT_IN;
            end
        end
    end

    // event-driven image values
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            limit_r <= '0;
            pset_r  <= '0;
        end else begin
            for (int i = 0; i < N_LIMIT; i++) begin
                if (LIMIT_EVT[i]) begin
                    limit_r[i] <= LIMIT_IN[i];
                end
            end
            if (PSET_IN != pset_r) begin
                pset_r <= PSET_IN;
            end
        end
    end

    // control word: taken every cycle, echoed on the slow tick
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ctrl_rx_r <= '0;
            echo_r    <= '0;
        end else begin
            ctrl_rx_r <= LINK.ctrl_word;
            if (stick_r) begin
                echo_r <= ctrl_rx_r;
            end
        end
    end

    assign rd_cur = {LINK.rd_idx, LINK.rd_sub, LINK.rd_pad};
    assign wr_cur = {LINK.wr_idx, LINK.wr_sub, LINK.wr_pad, LINK.wr_val};
    assign rd_go  = (rd_cur != rd_last_r) && (LINK.rd_idx != IDX_NOP);
    assign wr_go  = (wr_cur != wr_last_r) && (LINK.wr_idx != IDX_NOP);

    // dictionary read decode
    always_comb begin
        rd_err_nxt = ERR_NONE;
        rd_val_nxt = '0;
        if (LINK.rd_idx == IDX_IMAGE) begin
            case (LINK.rd_sub)
                SUB_ELEC: rd_val_nxt = elec_r;
                SUB_AOUT: rd_val_nxt = aout_r;
                SUB_PSET: rd_val_nxt = {16'h0000, pset_r};
                default:  rd_err_nxt = ERR_NO_OBJ;
            endcase
        end else if (LINK.rd_idx == IDX_USER) begin
            case (LINK.rd_sub)
                SUB_U32: rd_val_nxt = obj_u32_r;
                SUB_U16: rd_val_nxt = {16'h0000, obj_u16_r};
                SUB_U8:  rd_val_nxt = {24'h000000, obj_u8_r};
                default: rd_err_nxt = ERR_NO_OBJ;
            endcase
        end else begin
            rd_err_nxt = ERR_NO_OBJ;
        end
    end

    // dictionary write decode
    always_comb begin
        wr_err_nxt = ERR_NO_OBJ;
        if (LINK.wr_idx == IDX_IMAGE) begin
            case (LINK.wr_sub)
                SUB_ELEC, SUB_AOUT, SUB_PSET: wr_err_nxt = ERR_RO;
                default:                      wr_err_nxt = ERR_NO_OBJ;
            endcase
        end else if (LINK.wr_idx == IDX_USER) begin
            case (LINK.wr_sub)
                SUB_U32, SUB_U16, SUB_U8: wr_err_nxt = ERR_NONE;
                default:                  wr_err_nxt = ERR_NO_OBJ;
            endcase
        end
    end

    // writable objects; narrow types take only their low bits
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            obj_u32_r <= '0;
            obj_u16_r <= '0;
            obj_u8_r  <= '0;
        end else if (wr_go && wr_err_nxt == ERR_NONE) begin
            case (LINK.wr_sub)
                SUB_U32: obj_u32_r <= LINK.wr_val;
                SUB_U16: obj_u16_r <= 16'(LINK.wr_val & MASK_16);
                SUB_U8:  obj_u8_r  <= 8'(LINK.wr_val & MASK_8);
                default: obj_u32_r <= obj_u32_r;
            endcase
        end
    end

    // change detection; index-zero requests still count as seen
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rd_last_r <= '0;
            wr_last_r <= '0;
        end else begin
            rd_last_r <= rd_cur;
            wr_last_r <= wr_cur;
        end
    end

    // reply contents change only on a processed request
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rd_idx_r <= '0;
            rd_sub_r <= '0;
            rd_err_r <= '0;
            rd_val_r <= '0;
        end else if (rd_go) begin
            rd_idx_r <= LINK.rd_idx;
            rd_sub_r <= LINK.rd_sub;
            rd_err_r <= rd_err_nxt;
            rd_val_r <= rd_val_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            wr_idx_r <= '0;
            wr_sub_r <= '0;
            wr_err_r <= '0;
        end else if (wr_go) begin
            wr_idx_r <= LINK.wr_idx;
            wr_sub_r <= LINK.wr_sub;
            wr_err_r <= wr_err_nxt;
        end
    end

    // replies are published on the slow tick
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            prd_idx_r <= '0;
            prd_sub_r <= '0;
            prd_err_r <= '0;
            prd_val_r <= '0;
            pwr_idx_r <= '0;
            pwr_sub_r <= '0;
            pwr_err_r <= '0;
        end else if (stick_r) begin
            prd_idx_r <= rd_idx_r;
            prd_sub_r <= rd_sub_r;
            prd_err_r <= rd_err_r;
            prd_val_r <= rd_val_r;
            pwr_idx_r <= wr_idx_r;
            pwr_sub_r <= wr_sub_r;
            pwr_err_r <= wr_err_r;
        end
    end

    assign LINK.elec_val   = elec_r;
    assign LINK.bus_val    = bus_r;
    assign LINK.calc_val   = calc_r;
    assign LINK.limit_val  = limit_r;
    assign LINK.ext_val    = ext_r;
    assign LINK.aout_val   = aout_r;
    assign LINK.ctrl_echo  = echo_r;
    assign LINK.pset_num   = pset_r;
    assign LINK.rd_rep_idx = prd_idx_r;
    assign LINK.rd_rep_sub = prd_sub_r;
    assign LINK.rd_rep_err = prd_err_r;
    assign LINK.rd_rep_val = prd_val_r;
    assign LINK.wr_rep_idx = pwr_idx_r;
    assign LINK.wr_rep_sub = pwr_sub_r;
    assign LINK.wr_rep_err = pwr_err_r;
    assign CTRL_WORD_OUT   = ctrl_rx_r;
endmodule : fbimg_device

// *** hdl/fbimg_pkg.sv ***
// shared constants for the fieldbus input image and its controller
package fbimg_pkg;
    localparam int          CLK_NS      = 40;
    localparam int          T_FAST_NS   = 520000;
    localparam int          T_SLOW_NS   = 1000000;
    localparam int          FAST_CYC_DEF = T_FAST_NS / CLK_NS;
    localparam int          SLOW_CYC_DEF = T_SLOW_NS / CLK_NS;
    localparam int          WAIT_CYC_DEF = 2 * SLOW_CYC_DEF;
    localparam int          TW          = 16;
    localparam int          N_BUS       = 6;
    localparam int          N_CALC      = 6;
    localparam int          N_LIMIT     = 4;
    localparam logic [15:0] IDX_NOP     = 16'h0000;
    localparam logic [15:0] IDX_IMAGE   = 16'h2000;
    localparam logic [15:0] IDX_USER    = 16'h2001;
    localparam logic [7:0]  SUB_ELEC    = 8'h01;
    localparam logic [7:0]  SUB_AOUT    = 8'h02;
    localparam logic [7:0]  SUB_PSET    = 8'h03;
    localparam logic [7:0]  SUB_U32     = 8'h01;
    localparam logic [7:0]  SUB_U16     = 8'h02;
    localparam logic [7:0]  SUB_U8      = 8'h03;
    localparam logic [7:0]  ERR_NONE    = 8'h00;
    localparam logic [7:0]  ERR_NO_OBJ  = 8'h01;
    localparam logic [7:0]  ERR_RO      = 8'h02;
    localparam logic [7:0]  PAD_VAL     = 8'h00;
    localparam logic [31:0] MASK_16     = 32'h0000ffff;
    localparam logic [31:0] MASK_8      = 32'h000000ff;
endpackage : fbimg_pkg

// *** hdl/fbimg_if.sv ***
// cyclic image and request lines between device and controller
`timescale 1ns/1ps
interface fbimg_if;
    import fbimg_pkg::*;
    logic [31:0]              elec_val;
    logic [N_BUS-1:0][31:0]   bus_val;
    logic [N_CALC-1:0][31:0]  calc_val;
    logic [N_LIMIT-1:0][31:0] limit_val;
    logic [31:0]              ext_val;
    logic [31:0]              aout_val;
    logic [31:0]              ctrl_echo;
    logic [15:0]              pset_num;
    logic [15:0]              rd_rep_idx;
    logic [7:0]               rd_rep_sub;
    logic [7:0]               rd_rep_err;
    logic [31:0]              rd_rep_val;
    logic [15:0]              wr_rep_idx;
    logic [7:0]               wr_rep_sub;
    logic [7:0]               wr_rep_err;
    logic [31:0]              ctrl_word;
    logic [15:0]              rd_idx;
    logic [7:0]               rd_sub;
    logic [7:0]               rd_pad;
    logic [15:0]              wr_idx;
    logic [7:0]               wr_sub;
    logic [7:0]               wr_pad;
    logic [31:0]              wr_val;

    modport dev (
        output elec_val, bus_val, calc_val, limit_val, ext_val, aout_val,
        output ctrl_echo, pset_num,
        output rd_rep_idx, rd_rep_sub, rd_rep_err, rd_rep_val,
        output wr_rep_idx, wr_rep_sub, wr_rep_err,
        input  ctrl_word, rd_idx, rd_sub, rd_pad,
        input  wr_idx, wr_sub, wr_pad, wr_val
    );
    modport ctl (
        input  elec_val, bus_val, calc_val, limit_val, ext_val, aout_val,
        input  ctrl_echo, pset_num,
        input  rd_rep_idx, rd_rep_sub, rd_rep_err, rd_rep_val,
        input  wr_rep_idx, wr_rep_sub, wr_rep_err,
        output ctrl_word, rd_idx, rd_sub, rd_pad,
        output wr_idx, wr_sub, wr_pad, wr_val
    );
endinterface : fbimg_if

// *** hdl/fbimg_ctrl.sv ***
// controller end: issues control word and dictionary requests, checks replies
`timescale 1ns/1ps
module fbimg_ctrl
    import fbimg_pkg::*;
#(
    parameter int WAIT_CYC = WAIT_CYC_DEF
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        CMD_CTRL,
    input  wire logic [31:0] CTRL_IN,
    input  wire logic        CMD_RD,
    input  wire logic [15:0] RD_IDX,
    input  wire logic [7:0]  RD_SUB,
    input  wire logic        CMD_WR,
    input  wire logic [15:0] WR_IDX,
    input  wire logic [7:0]  WR_SUB,
    input  wire logic [31:0] WR_VAL,
    output logic             BUSY,
    output logic             DONE,
    output logic             FAIL,
    output logic      [31:0] RD_DATA,
    output logic      [7:0]  ERR_OUT,
    fbimg_if.ctl             LINK
);
    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_BLANK = 3'b010,
        S_WAIT  = 3'b100
    } fbimg_cst_t;

    typedef enum logic [1:0] {
        K_CTRL = 2'h0,
        K_RD   = 2'h1,
        K_WR   = 2'h2
    } fbimg_kind_t;

    fbimg_cst_t    state_r;
    fbimg_kind_t   kind_r;
    logic [TW-1:0] wcnt_r;
    logic [31:0]   ctrl_r;
    logic [15:0]   rd_idx_r;
    logic [7:0]    rd_sub_r;
    logic [15:0]   wr_idx_r;
    logic [7:0]    wr_sub_r;
    logic [31:0]   wr_val_r;
    logic [15:0]   want_idx_r;
    logic          busy_r;
    logic          done_r;
    logic          fail_r;
    logic [31:0]   rd_data_r;
    logic [7:0]    err_r;
    logic          ok_nxt;
    logic [7:0]    err_nxt;

    // verdict for the pending transfer
    always_comb begin
        ok_nxt  = 1'b0;
        err_nxt = ERR_NONE;
        case (kind_r)
            K_CTRL: ok_nxt = (LINK.ctrl_echo == ctrl_r);
            K_RD: begin
                err_nxt = LINK.rd_rep_err;
                ok_nxt  = (LINK.rd_rep_idx == want_idx_r) &&
                          (LINK.rd_rep_sub == rd_sub_r) &&
                          (LINK.rd_rep_err == ERR_NONE);
            end
            K_WR: begin
                err_nxt = LINK.wr_rep_err;
                ok_nxt  = (LINK.wr_rep_idx == want_idx_r) &&
                          (LINK.wr_rep_err == ERR_NONE);
            end
            default: ok_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_r    <= S_IDLE;
            kind_r     <= K_CTRL;
            wcnt_r     <= '0;
            ctrl_r     <= '0;
            rd_idx_r   <= IDX_NOP;
            rd_sub_r   <= '0;
            wr_idx_r   <= IDX_NOP;
            wr_sub_r   <= '0;
            wr_val_r   <= '0;
            want_idx_r <= IDX_NOP;
            busy_r     <= 1'b0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    wcnt_r <= '0;
                    if (CMD_CTRL) begin
                        kind_r  <= K_CTRL;
                        ctrl_r  <= CTRL_IN;
                        busy_r  <= 1'b1;
                        state_r <= S_WAIT;
                    end else if (CMD_RD) begin
                        // index forced to zero first so a repeat is a change
                        kind_r     <= K_RD;
                        rd_idx_r   <= IDX_NOP;
                        rd_sub_r   <= RD_SUB;
                        want_idx_r <= RD_IDX;
                        busy_r     <= 1'b1;
                        state_r    <= S_BLANK;
                    end else if (CMD_WR) begin
                        kind_r     <= K_WR;
                        wr_idx_r   <= IDX_NOP;
                        wr_sub_r   <= WR_SUB;
                        wr_val_r   <= WR_VAL;
                        want_idx_r <= WR_IDX;
                        busy_r     <= 1'b1;
                        state_r    <= S_BLANK;
                    end
                end
                S_BLANK: begin
                    if (kind_r == K_RD) begin
                        rd_idx_r <= want_idx_r;
                    end else begin
                        wr_idx_r <= want_idx_r;
                    end
                    state_r <= S_WAIT;
                end
                S_WAIT: begin
                    // wait two publish periods so a stale reply is gone
                    if (wcnt_r == TW'(WAIT_CYC - 1)) begin
                        busy_r  <= 1'b0;
                        state_r <= S_IDLE;
                    end else begin
                        wcnt_r <= wcnt_r + 1'b1;
                    end
                end
                default: begin
                    busy_r  <= 1'b0;
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            done_r    <= 1'b0;
            fail_r    <= 1'b0;
            rd_data_r <= '0;
            err_r     <= '0;
        end else begin
            done_r <= 1'b0;
            fail_r <= 1'b0;
            if (state_r == S_WAIT && wcnt_r == TW'(WAIT_CYC - 1)) begin
                done_r <= ok_nxt;
                fail_r <= !ok_nxt;
                err_r  <= err_nxt;
                if (kind_r == K_RD && ok_nxt) begin
                    rd_data_r <= LINK.rd_rep_val;
                end
            end
        end
    end

    assign LINK.ctrl_word = ctrl_r;
    assign LINK.rd_idx    = rd_idx_r;
    assign LINK.rd_sub    = rd_sub_r;
    assign LINK.rd_pad    = PAD_VAL;
    assign LINK.wr_idx    = wr_idx_r;
    assign LINK.wr_sub    = wr_sub_r;
    assign LINK.wr_pad    = PAD_VAL;
    assign LINK.wr_val    = wr_val_r;
    assign BUSY           = busy_r;
    assign DONE           = done_r;
    assign FAIL           = fail_r;
    assign RD_DATA        = rd_data_r;
    assign ERR_OUT        = err_r;
endmodule : fbimg_ctrl

// *** test/fbimg_chk.sv ***
// concurrent checks on the image and reply lines
`timescale 1ns/1ps
module fbimg_chk
    import fbimg_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic [31:0] elec_val,
    input wire logic [31:0] ctrl_word,
    input wire logic [31:0] ctrl_echo,
    input wire logic [15:0] rd_rep_idx,
    input wire logic [7:0]  rd_rep_sub,
    input wire logic [7:0]  rd_rep_err,
    input wire logic [31:0] rd_rep_val,
    input wire logic [15:0] wr_rep_idx
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    elec_hold_a: assert property (
        $changed(elec_val) |=> $stable(elec_val)[*8])
        else $error("electrical value refreshed too soon");
    echo_hold_a: assert property (
        $changed(ctrl_echo) |=> $stable(ctrl_echo)[*8])
        else $error("control echo refreshed too soon");
    echo_match_a: assert property (
        $changed(ctrl_echo) |-> ctrl_echo == ctrl_word)
        else $error("control echo differs from control word");
    rd_hold_a: assert property (
        $changed(rd_rep_idx) |=> $stable(rd_rep_idx)[*8])
        else $error("read reply not held");
    rd_nonzero_a: assert property (
        $changed(rd_rep_idx) |-> rd_rep_idx != IDX_NOP)
        else $error("read reply for index zero");
    wr_nonzero_a: assert property (
        $changed(wr_rep_idx) |-> wr_rep_idx != IDX_NOP)
        else $error("write reply for index zero");
    u16_field_a: assert property (
        rd_rep_idx == IDX_USER && rd_rep_sub == SUB_U16
        |-> rd_rep_val[31:16] == 16'h0000)
        else $error("16-bit value upper half not zero");
    u8_field_a: assert property (
        rd_rep_idx == IDX_USER && rd_rep_sub == SUB_U8
        |-> rd_rep_val[31:8] == 24'h000000)
        else $error("8-bit value upper bits not zero");
    rd_noobj_a: assert property (
        $changed(rd_rep_idx) && rd_rep_idx != IDX_IMAGE
        && rd_rep_idx != IDX_USER |-> rd_rep_err == ERR_NO_OBJ)
        else $error("unknown object read without error");
endmodule : fbimg_chk

// *** test/test_fieldbus_input_image.sv ***
// bench: device and controller joined by the image lines
`timescale 1ns/1ps
module test_fieldbus_input_image;
    import fbimg_pkg::*;
    localparam int FC = 13;
    localparam int SC = 25;
    localparam int WC = 54;
    logic                     SYS_CLK, RST_N, AOUT_FAST;
    logic [31:0]              ELEC_IN, EXT_IN, AOUT_IN, CTRL_IN, WR_VAL;
    logic [N_BUS-1:0][31:0]   BUS_IN;
    logic [N_CALC-1:0][31:0]  CALC_IN;
    logic [N_LIMIT-1:0][31:0] LIMIT_IN, lim_exp;
    logic [N_LIMIT-1:0]       LIMIT_EVT;
    logic                     CMD_CTRL, CMD_RD, CMD_WR, BUSY, DONE, FAIL;
    logic [15:0]              PSET_IN, RD_IDX, WR_IDX;
    logic [7:0]               RD_SUB, WR_SUB, ERR_OUT;
    logic [31:0]              RD_DATA, CTRL_WORD_OUT;
    logic                     got_fail;
    int                       n_mismatch, n_checks;
    logic [31:0]              u_obj [3];

    fbimg_if link ();
    fbimg_device #(.FAST_CYC(FC), .SLOW_CYC(SC)) i_fbimg_device (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .ELEC_IN(ELEC_IN),
        .BUS_IN(BUS_IN), .CALC_IN(CALC_IN), .LIMIT_IN(LIMIT_IN),
        .LIMIT_EVT(LIMIT_EVT), .EXT_IN(EXT_IN), .AOUT_IN(AOUT_IN),
        .AOUT_FAST(AOUT_FAST), .PSET_IN(PSET_IN),
        .CTRL_WORD_OUT(CTRL_WORD_OUT), .LINK(link));
    fbimg_ctrl #(.WAIT_CYC(WC)) i_fbimg_ctrl (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CMD_CTRL(CMD_CTRL),
        .CTRL_IN(CTRL_IN), .CMD_RD(CMD_RD), .RD_IDX(RD_IDX),
        .RD_SUB(RD_SUB), .CMD_WR(CMD_WR), .WR_IDX(WR_IDX), .WR_SUB(WR_SUB),
        .WR_VAL(WR_VAL), .BUSY(BUSY), .DONE(DONE), .FAIL(FAIL),
        .RD_DATA(RD_DATA), .ERR_OUT(ERR_OUT), .LINK(link));
    fbimg_chk i_fbimg_chk (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .elec_val(link.elec_val),
        .ctrl_word(link.ctrl_word), .ctrl_echo(link.ctrl_echo),
        .rd_rep_idx(link.rd_rep_idx), .rd_rep_sub(link.rd_rep_sub),
        .rd_rep_err(link.rd_rep_err), .rd_rep_val(link.rd_rep_val),
        .wr_rep_idx(link.wr_rep_idx));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : cycles

    // kind 0 control, 1 read, 2 write; waits for the verdict pulse
    task automatic cmd(input int k, input logic [15:0] idx,
                       input logic [7:0] sub, input logic [31:0] v);
        int n;
        n = 0;
        cycles(1);
        CMD_CTRL = (k == 0);
        CMD_RD   = (k == 1);
        CMD_WR   = (k == 2);
        {CTRL_IN, WR_VAL, RD_IDX, WR_IDX, RD_SUB, WR_SUB} =
            {v, v, idx, idx, sub, sub};
        cycles(1);
        {CMD_CTRL, CMD_RD, CMD_WR} = 3'h0;
        chk("busy", 32'h1, {31'h0, BUSY});
        while (DONE !== 1'b1 && FAIL !== 1'b1 && n < WC + 10) begin
            cycles(1);
            n++;
        end
        if (n >= WC + 10) begin
            n_mismatch++;
            stop_test();
        end
        got_fail = FAIL;
        chk("idle", 32'h0, {31'h0, BUSY});
    endtask : cmd

    function automatic logic [31:0] fit(input logic [7:0] s,
                                        input logic [31:0] v);
        return s == SUB_U16 ? (v & MASK_16) : s == SUB_U8 ? (v & MASK_8) : v;
    endfunction : fit

    // user object written then read back through the dictionary
    task automatic wr_rd(input logic [7:0] s, input logic [31:0] v);
        cmd(2, IDX_USER, s, v);
        u_obj[s-1] = fit(s, v);
        chk("write fail", 32'h0, {31'h0, got_fail});
        chk("write err", {24'h0, ERR_NONE}, {24'h0, ERR_OUT});
        chk("write sub", {24'h0, s}, {24'h0, link.wr_rep_sub});
        cmd(1, IDX_USER, s, 32'h0);
        chk("read fail", 32'h0, {31'h0, got_fail});
        chk("read data", u_obj[s-1], RD_DATA);
    endtask : wr_rd

    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end

    initial begin
        #(100000 * 40);
        n_mismatch++;
        stop_test();
    end

    initial begin
        logic [31:0] r;
        n_mismatch = 0;
        n_checks = 0;
        u_obj = '{32'h0, 32'h0, 32'h0};
        {RST_N, AOUT_FAST, ELEC_IN, EXT_IN, AOUT_IN, CTRL_IN, WR_VAL} = '0;
        {BUS_IN, CALC_IN, LIMIT_IN, LIMIT_EVT, PSET_IN} = '0;
        {CMD_CTRL, CMD_RD, CMD_WR, RD_IDX, WR_IDX, RD_SUB, WR_SUB} = '0;
        r = $urandom(67140);
        cycles(8);
        RST_N = 1'b1;
        ELEC_IN = $urandom;
        EXT_IN = $urandom;
        AOUT_IN = $urandom;
        AOUT_FAST = 1'b1;
        foreach (BUS_IN[i]) BUS_IN[i] = $urandom;
        foreach (CALC_IN[i]) CALC_IN[i] = $urandom;
        cycles(SC + 2);
        chk("elec", ELEC_IN, link.elec_val);
        foreach (BUS_IN[i]) chk("bus", BUS_IN[i], link.bus_val[i]);
        foreach (CALC_IN[i]) chk("calc", CALC_IN[i], link.calc_val[i]);
        chk("ext", EXT_IN, link.ext_val);
        ELEC_IN = $urandom;
        AOUT_IN = $urandom;
        cycles(FC + 2);
        chk("elec fast", ELEC_IN, link.elec_val);
        chk("aout fast", AOUT_IN, link.aout_val);
        AOUT_FAST = 1'b0;
        AOUT_IN = $urandom;
        cycles(SC + 2);
        chk("aout slow", AOUT_IN, link.aout_val);
        $display("image refresh test done");
        for (int i = 0; i < N_LIMIT; i++) begin
            lim_exp[i] = $urandom;
            LIMIT_IN[i] = lim_exp[i];
            LIMIT_EVT[i] = 1'b1;
            cycles(1);
            LIMIT_EVT = '0;
            LIMIT_IN[i] = ~lim_exp[i];
        end
        PSET_IN = $urandom;
        cycles(SC + 2);
        foreach (lim_exp[i]) chk("limit", lim_exp[i], link.limit_val[i]);
        chk("pset", {16'h0, PSET_IN}, {16'h0, link.pset_num});
        $display("event value test done");
        r = $urandom;
        cmd(0, IDX_NOP, 8'h00, r);
        chk("echo", r, link.ctrl_echo);
        chk("ctrl fail", 32'h0, {31'h0, got_fail});
        chk("ctrl out", r, CTRL_WORD_OUT);
        $display("control echo test done");
        for (int s = 1; s <= 3; s++) wr_rd(s[7:0], $urandom);
        repeat (4) wr_rd(8'($urandom_range(1, 3)), $urandom);
        cmd(1, IDX_IMAGE, SUB_ELEC, 32'h0);
        chk("elec raw", ELEC_IN, RD_DATA);
        cmd(1, IDX_IMAGE, SUB_PSET, 32'h0);
        chk("pset raw", {16'h0, PSET_IN}, RD_DATA);
        $display("dictionary access test done");
        cmd(2, IDX_IMAGE, SUB_ELEC, $urandom);
        chk("ro fail", 32'h1, {31'h0, got_fail});
        chk("ro err", {24'h0, ERR_RO}, {24'h0, ERR_OUT});
        cmd(1, 16'h3000, SUB_U32, 32'h0);
        chk("noobj fail", 32'h1, {31'h0, got_fail});
        chk("noobj err", {24'h0, ERR_NO_OBJ}, {24'h0, ERR_OUT});
        cmd(1, IDX_NOP, SUB_U32, 32'h0);
        chk("nop fail", 32'h1, {31'h0, got_fail});
        chk("nop held", 32'h3000, {16'h0, link.rd_rep_idx});
        $display("refusal test done");
        RST_N = 1'b0;
        cycles(2);
        RST_N = 1'b1;
        cycles(1);
        chk("elec reset", 32'h0, link.elec_val);
        u_obj = '{32'h0, 32'h0, 32'h0};
        cmd(1, IDX_USER, SUB_U32, 32'h0);
        chk("u32 reset", u_obj[0], RD_DATA);
        chk("u32 rd fail", 32'h0, {31'h0, got_fail});
        $display("second reset test done");
        stop_test();
    end
endmodule : test_fieldbus_input_image
